// ==== shared/aofc_pkg.sv ====
// Shared constants and types for the output format configuration block
`default_nettype none
package aofc_pkg;
    localparam logic [12:0] ADDR_FMT = 13'h0014;
    localparam logic [12:0] ADDR_ADJ = 13'h0015;
    localparam logic [12:0] ADDR_PHASE = 13'h0016;
    localparam logic [12:0] ADDR_PATT = 13'h0019;
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam logic [7:0] ADJ_RESET = 8'h00;
    localparam logic [7:0] PHASE_RESET = 8'h03;
    localparam logic [7:0] PATT_RESET = 8'h00;
    localparam logic [7:0] FMT_MASK = 8'h47;
    localparam logic [7:0] ADJ_MASK = 8'h30;
    localparam logic [7:0] PHASE_MASK = 8'h0f;
    localparam logic [7:0] PATT_MASK = 8'hff;
    localparam int FMT_LOWPWR_BIT = 6;
    localparam int FMT_INV_BIT = 2;
    localparam int FMT_CODE_LSB = 0;
    localparam int ADJ_TERM_LSB = 4;
    localparam int PHASE_LSB = 0;
    localparam logic [3:0] PHASE_LAST_STEP = 4'ha;
    localparam logic [3:0] PHASE_CLAMP_SEL = 4'hb;
    localparam int NUM_PHASES = 12;
    localparam logic [1:0] CODE_OFFSET = 2'h0;
    localparam logic [1:0] CODE_TWOS = 2'h1;
    localparam logic [1:0] TERM_CODE_NONE = 2'h0;
    localparam logic [1:0] TERM_CODE_200 = 2'h1;
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
    localparam logic [4:0] SPI_DATA_LAST = 5'h07;
    localparam int SPI_RW_BIT = 15;

    typedef enum logic [1:0] {
        AOFC_TERM_NONE,
        AOFC_TERM_200,
        AOFC_TERM_100
    } aofc_term_t;

    typedef struct packed {
        logic low_power;
        logic invert;
        logic [1:0] code;
    } aofc_fmt_t;

    typedef struct packed {
        logic wr;
        logic [12:0] addr;
        logic [7:0] wdata;
    } aofc_wr_t;
endpackage
`default_nettype wire

// ==== design/aofc_spi_port.sv ====
// Serial port slave: 16-bit instruction then one data byte
`timescale 1ns/100ps
`default_nettype none
module aofc_spi_port (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic csb_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    output aofc_pkg::aofc_wr_t bus_o,
    input wire logic [7:0] rdata_i
);
    import aofc_pkg::*;

    typedef enum {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} aofc_spi_st_t;

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_d;
    aofc_spi_st_t state, next_state;
    logic [4:0] cnt, next_cnt;
    logic [15:0] ins, next_ins;
    logic [7:0] dsh, next_dsh;
    logic loaded, next_loaded;
    logic oe, next_oe;
    aofc_wr_t bus, next_bus;
    logic sclk_s, csb_s, sdi_s, rise, fall, is_read;

    assign sclk_s = sync2[2];
    assign csb_s = sync2[1];
    assign sdi_s = sync2[0];
    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign is_read = ins[SPI_RW_BIT];

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_ins = ins;
        next_dsh = dsh;
        next_loaded = loaded;
        next_oe = oe;
        next_bus = bus;
        next_bus.wr = 1'b0;
        if (csb_s) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_INSTR;
                    next_cnt = 5'h00;
                    next_loaded = 1'b0;
                end
                ST_INSTR: begin
                    if (rise) begin
                        next_ins = {ins[14:0], sdi_s};
                        next_cnt = cnt + 5'h01;
                        if (cnt == SPI_INSTR_LAST) begin
                            next_state = ST_DATA;
                            next_cnt = 5'h00;
                            next_bus.addr = {ins[11:0], sdi_s};
                        end
                    end
                end
                ST_DATA: begin
                    if (is_read && fall) begin
                        next_oe = 1'b1;
                        next_loaded = 1'b1;
                        next_dsh = loaded ? {dsh[6:0], 1'b0} : rdata_i;
                    end
                    if (rise) begin
                        next_cnt = cnt + 5'h01;
                        if (!is_read) begin
                            next_dsh = {dsh[6:0], sdi_s};
                        end
                        if (cnt == SPI_DATA_LAST) begin
                            next_state = ST_DONE;
                            next_bus.wr = ~is_read;
                            next_bus.wdata = {dsh[6:0], sdi_s};
                        end
                    end
                end
                ST_DONE: begin
                    if (fall) begin
                        next_oe = 1'b0;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1 <= 3'h2;
            sync2 <= 3'h2;
            sclk_d <= 1'b0;
            state <= ST_IDLE;
            cnt <= 5'h00;
            ins <= 16'h0000;
            dsh <= 8'h00;
            loaded <= 1'b0;
            oe <= 1'b0;
            bus <= '0;
        end else begin
            sync1 <= {sclk_i, csb_i, sdio_i};
            sync2 <= sync1;
            sclk_d <= sclk_s;
            state <= next_state;
            cnt <= next_cnt;
            ins <= next_ins;
            dsh <= next_dsh;
            loaded <= next_loaded;
            oe <= next_oe;
            bus <= next_bus;
        end
    end

    assign sdio_o = dsh[7];
    assign sdio_oe_o = oe;
    assign bus_o = bus;
endmodule
`default_nettype wire

// ==== design/aofc_formatter.sv ====
// Output data coding: pattern select, twos complement and inversion
`timescale 1ns/100ps
`default_nettype none
module aofc_formatter #(
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire aofc_pkg::aofc_fmt_t fmt_i,
    input wire logic test_pat_en_i,
    input wire logic [DATA_W-1:0] pattern_i,
    input wire logic [DATA_W-1:0] sample_i,
    input wire logic sample_vld_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_vld_o
);
    import aofc_pkg::*;

    logic [DATA_W-1:0] next_data;
    logic next_vld;
    logic [DATA_W-1:0] src;

    always_comb begin
        src = test_pat_en_i ? pattern_i : sample_i;
        if (fmt_i.code == CODE_TWOS) begin
            src[DATA_W-1] = ~src[DATA_W-1];
        end
        if (fmt_i.invert) begin
            src = ~src;
        end
        next_data = sample_vld_i ? src : data_o;
        next_vld = sample_vld_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_o <= '0;
            data_vld_o <= 1'b0;
        end else begin
            data_o <= next_data;
            data_vld_o <= next_vld;
        end
    end

    a_invert_data: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        sample_vld_i && !test_pat_en_i && fmt_i.invert
        && fmt_i.code == CODE_OFFSET |=> data_o == ~$past(sample_i))
        else $error("Inverted data mismatch");
    a_twos_msb: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        sample_vld_i && !test_pat_en_i && !fmt_i.invert
        && fmt_i.code == CODE_TWOS |=> data_o ==
        {~$past(sample_i[DATA_W-1]), $past(sample_i[DATA_W-2:0])})
        else $error("Twos complement coding mismatch");
    a_pattern_fmt: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        sample_vld_i && test_pat_en_i && fmt_i.invert
        && fmt_i.code == CODE_OFFSET |=> data_o == ~$past(pattern_i))
        else $error("Test pattern not formatted");
    a_capture_kept: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        sample_vld_i |=> data_vld_o ##1 (data_vld_o == $past(sample_vld_i)))
        else $error("Sample capture disturbed");
endmodule
`default_nettype wire

// ==== design/aofc_top.sv ====
// Output format, drive, clock phase and user pattern configuration
//
// Functional notes
// - Phase field bits 3..0; codes 0..10 give 0..600 degrees in 60 steps.
// - Phase codes 11 through 15 all give the 660 degree offset.
// - Phase register resets to 0x03, clock at 180 degrees.
// - Phase only picks the divider phase; sample capture is unaffected.
// - User pattern one low byte, 8 bits, reset 0x00, writable.
// - Format bit 2 set inverts the output data bits; default off.
// - Format bits 1..0: 00 offset binary, 01 twos complement.
// - Format bit 6 picks standard or low power reduced-swing signalling.
// - Termination bits 5..4: 00 none, 01 200 ohm, 1x 100 ohm.
// - Test patterns use the same output coding as normal data.
`timescale 1ns/100ps
`default_nettype none
module aofc_top #(
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic csb_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    input wire logic [DATA_W-1:0] sample_i,
    input wire logic sample_vld_i,
    input wire logic test_pat_en_i,
    input wire logic [aofc_pkg::NUM_PHASES-1:0] div_phase_i,
    output logic data_clock_output_o,
    output logic [3:0] phase_sel_o,
    output logic lvds_low_power_o,
    output aofc_pkg::aofc_term_t term_sel_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_vld_o
);
    import aofc_pkg::*;

    aofc_wr_t bus;
    logic [7:0] rdata;
    logic [7:0] fmt_reg, next_fmt;
    logic [7:0] adj_reg, next_adj;
    logic [7:0] phase_reg, next_phase;
    logic [7:0] patt_reg, next_patt;
    logic [3:0] next_phase_sel;
    aofc_term_t next_term;
    aofc_fmt_t fmt;

    function automatic logic [7:0] read_reg(
        input logic [12:0] addr,
        input logic [7:0] f,
        input logic [7:0] a,
        input logic [7:0] p,
        input logic [7:0] u
    );
        case (addr)
            ADDR_FMT: read_reg = f;
            ADDR_ADJ: read_reg = a;
            ADDR_PHASE: read_reg = p;
            ADDR_PATT: read_reg = u;
            default: read_reg = 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] clamp_phase(input logic [7:0] p);
        logic [3:0] code;
        code = p[PHASE_LSB +: 4];
        if (code > PHASE_LAST_STEP) begin
            clamp_phase = PHASE_CLAMP_SEL;
        end else begin
            clamp_phase = code;
        end
    endfunction

    function automatic aofc_term_t decode_term(input logic [7:0] a);
        case (a[ADJ_TERM_LSB +: 2])
            TERM_CODE_NONE: decode_term = AOFC_TERM_NONE;
            TERM_CODE_200: decode_term = AOFC_TERM_200;
            default: decode_term = AOFC_TERM_100;
        endcase
    endfunction

    aofc_spi_port u_spi (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sclk_i(sclk_i),
        .csb_i(csb_i),
        .sdio_i(sdio_i),
        .sdio_o(sdio_o),
        .sdio_oe_o(sdio_oe_o),
        .bus_o(bus),
        .rdata_i(rdata)
    );

    // Reserved bits are not stored and read back as zero
    assign rdata = read_reg(bus.addr, fmt_reg, adj_reg, phase_reg, patt_reg);

    always_comb begin
        next_fmt = fmt_reg;
        next_adj = adj_reg;
        next_phase = phase_reg;
        next_patt = patt_reg;
        if (bus.wr) begin
            case (bus.addr)
                ADDR_FMT: next_fmt = bus.wdata & FMT_MASK;
                ADDR_ADJ: next_adj = bus.wdata & ADJ_MASK;
                ADDR_PHASE: next_phase = bus.wdata & PHASE_MASK;
                ADDR_PATT: next_patt = bus.wdata & PATT_MASK;
                default: next_patt = patt_reg;
            endcase
        end
        next_phase_sel = clamp_phase(next_phase);
        next_term = decode_term(next_adj);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fmt_reg <= FMT_RESET;
            adj_reg <= ADJ_RESET;
            phase_reg <= PHASE_RESET;
            patt_reg <= PATT_RESET;
            phase_sel_o <= PHASE_RESET[3:0];
            term_sel_o <= AOFC_TERM_NONE;
        end else begin
            fmt_reg <= next_fmt;
            adj_reg <= next_adj;
            phase_reg <= next_phase;
            patt_reg <= next_patt;
            phase_sel_o <= next_phase_sel;
            term_sel_o <= next_term;
        end
    end

    // Phase only steers the clock mux, never the data path
    assign data_clock_output_o = div_phase_i[phase_sel_o];
    assign lvds_low_power_o = fmt_reg[FMT_LOWPWR_BIT];

    always_comb begin
        fmt.low_power = fmt_reg[FMT_LOWPWR_BIT];
        fmt.invert = fmt_reg[FMT_INV_BIT];
        fmt.code = fmt_reg[FMT_CODE_LSB +: 2];
    end

    aofc_formatter #(
        .DATA_W(DATA_W)
    ) u_fmt (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .fmt_i(fmt),
        .test_pat_en_i(test_pat_en_i),
        .pattern_i(patt_reg[DATA_W-1:0]),
        .sample_i(sample_i),
        .sample_vld_i(sample_vld_i),
        .data_o(data_o),
        .data_vld_o(data_vld_o)
    );

    a_phase_clamp: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        phase_reg[3:0] > PHASE_LAST_STEP |-> phase_sel_o == 4'hb)
        else $error("High phase code not clamped");
    a_phase_steps: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        phase_reg[3:0] <= PHASE_LAST_STEP
        |-> phase_sel_o == phase_reg[3:0])
        else $error("Phase select differs from code");
    a_phase_reset: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> phase_reg == 8'h03 && phase_sel_o == 4'h3)
        else $error("Phase reset value wrong");
    a_clock_mux: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        data_clock_output_o == div_phase_i[phase_sel_o])
        else $error("Output clock phase not selected");
    a_patt_write: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        bus.wr && bus.addr == ADDR_PATT
        |=> patt_reg == $past(bus.wdata))
        else $error("Pattern byte not written");
    a_low_power: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        bus.wr && bus.addr == ADDR_FMT
        |=> lvds_low_power_o == $past(bus.wdata[6]))
        else $error("Signalling select not updated");
    a_term_hundred: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        bus.wr && bus.addr == ADDR_ADJ && bus.wdata[5]
        |=> term_sel_o == AOFC_TERM_100)
        else $error("Termination not 100 ohm");
    a_term_none: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        adj_reg[5:4] == 2'h0 |=> term_sel_o == AOFC_TERM_NONE
        || $past(bus.wr))
        else $error("Termination not off");
endmodule
`default_nettype wire

// ==== verif/aofc_host_rx.sv ====
// Host receiver model that captures formatted output words
`timescale 1ns/100ps
`default_nettype none
module aofc_host_rx #(
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic vld_i,
    output logic [DATA_W-1:0] word_o,
    output logic [31:0] words_o
);
    // Latches a word only on its valid cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            word_o <= '0;
            words_o <= '0;
        end else if (vld_i) begin
            word_o <= data_i;
            words_o <= words_o + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/adc_output_format_config_tb_top.sv ====
// Self-checking bench for the output format configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    errors++; $display("mismatch t=%0t got %0h exp %0h", $time, got, exp); \
    end end
module adc_output_format_config_tb_top;
    import aofc_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sclk_i = 1'b0;
    logic csb_i = 1'b1;
    logic sdio_i = 1'b0;
    logic [7:0] sample_i = 8'h00;
    logic sample_vld_i = 1'b0;
    logic test_pat_en_i = 1'b0;
    logic [NUM_PHASES-1:0] div_phase_i = '0;
    logic sdio_o, sdio_oe_o, data_clock_output_o, lvds_low_power_o;
    logic data_vld_o;
    logic [3:0] phase_sel_o;
    aofc_term_t term_sel_o;
    logic [7:0] data_o, host_word;
    logic [31:0] host_words;
    int errors = 0;
    int check_count = 0;

    always #10 clk_i = ~clk_i;

    aofc_top #(.DATA_W(8)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sclk_i(sclk_i), .csb_i(csb_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
        .sdio_oe_o(sdio_oe_o), .sample_i(sample_i),
        .sample_vld_i(sample_vld_i), .test_pat_en_i(test_pat_en_i),
        .div_phase_i(div_phase_i),
        .data_clock_output_o(data_clock_output_o),
        .phase_sel_o(phase_sel_o), .lvds_low_power_o(lvds_low_power_o),
        .term_sel_o(term_sel_o), .data_o(data_o), .data_vld_o(data_vld_o));

    aofc_host_rx #(.DATA_W(8)) host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .data_i(data_o), .vld_i(data_vld_o), .word_o(host_word),
        .words_o(host_words));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One serial frame, MSB first; read bits sampled late in sclk low
    task automatic spi(input logic rd, input logic [12:0] addr,
                       input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] frame;
        frame = {rd, 2'h0, addr, wd};
        q = 8'h00;
        csb_i <= 1'b0;
        cyc(4);
        for (int i = 23; i >= 0; i--) begin
            sclk_i <= 1'b0;
            sdio_i <= frame[i];
            cyc(6);
            #1;
            if (i < 8) begin
                q[i] = sdio_o;
                `CHK(sdio_oe_o, rd)
            end
            @(posedge clk_i);
            sclk_i <= 1'b1;
            cyc(4);
        end
        sclk_i <= 1'b0;
        cyc(4);
        csb_i <= 1'b1;
        cyc(8);
        `CHK(sdio_oe_o, 1'b0)
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] q;
        spi(1'b1, a, 8'h00, q);
        `CHK(q, exp)
    endtask

    task automatic send(input logic [7:0] s, input logic [7:0] exp);
        logic [31:0] n;
        n = host_words;
        sample_i <= s;
        sample_vld_i <= 1'b1;
        @(posedge clk_i);
        sample_vld_i <= 1'b0;
        #1;
        `CHK(data_vld_o, 1'b1)
        `CHK(data_o, exp)
        @(posedge clk_i);
        #1;
        `CHK(data_vld_o, 1'b0)
        `CHK(host_word, exp)
        `CHK(host_words, n + 32'h1)
        @(posedge clk_i);
    endtask

    task automatic t_reset;
        `CHK(phase_sel_o, PHASE_RESET[3:0])
        `CHK(term_sel_o, AOFC_TERM_NONE)
        `CHK(lvds_low_power_o, 1'b0)
        rd(ADDR_FMT, FMT_RESET);
        rd(ADDR_ADJ, ADJ_RESET);
        rd(ADDR_PHASE, PHASE_RESET);
        rd(ADDR_PATT, PATT_RESET);
        rd(13'h0017, 8'h00);
    endtask

    task automatic t_phase;
        logic [3:0] e;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_PHASE, 8'(c));
            e = (c > 10) ? 4'hb : 4'(c);
            `CHK(phase_sel_o, e)
            div_phase_i <= 12'h001 << e;
            @(posedge clk_i);
            #1;
            `CHK(data_clock_output_o, 1'b1)
            @(posedge clk_i);
            div_phase_i <= ~(12'h001 << e);
            @(posedge clk_i);
            #1;
            `CHK(data_clock_output_o, 1'b0)
            @(posedge clk_i);
        end
        rd(ADDR_PHASE, 8'h0f);
        send(8'h5a, 8'h5a);
    endtask

    task automatic t_format;
        logic [7:0] f;
        for (int i = 0; i < 8; i++) begin
            f = {1'b0, i[2], 3'h0, i[1], 1'b0, i[0]};
            wr(ADDR_FMT, f);
            `CHK(lvds_low_power_o, i[2])
            send(8'h3c, 8'h3c ^ (i[0] ? 8'h80 : 8'h00)
                 ^ (i[1] ? 8'hff : 8'h00));
        end
        wr(ADDR_FMT, 8'hff);
        rd(ADDR_FMT, FMT_MASK);
    endtask

    task automatic t_term;
        aofc_term_t e;
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_ADJ, {2'h0, 2'(t), 4'h0});
            e = (t == 0) ? AOFC_TERM_NONE
                : (t == 1) ? AOFC_TERM_200 : AOFC_TERM_100;
            `CHK(term_sel_o, e)
        end
    endtask

    task automatic t_pattern;
        wr(ADDR_PATT, 8'ha5);
        rd(ADDR_PATT, 8'ha5);
        wr(ADDR_FMT, 8'h05);
        test_pat_en_i <= 1'b1;
        @(posedge clk_i);
        send(8'h00, ~(8'ha5 ^ 8'h80));
        wr(ADDR_FMT, 8'h04);
        send(8'h00, ~8'ha5);
        test_pat_en_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic end_of_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        cyc(16);
        sys_rst_i <= 1'b0;
        cyc(4);
        t_reset();
        t_phase();
        t_format();
        t_term();
        t_pattern();
        end_of_test();
    end

    initial begin
        cyc(60000);
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
